/* File: src/fss_pkg.sv */
/*
 * fss_pkg: opcode patterns, field positions, phase codes and status bit
 * positions shared by the fill/sleep/subtract execution block.
 * Assumes a 16-bit program word and an 8-bit data path.
 */
package fss_pkg;
	localparam int          FSS_DW          = 8;
	localparam int          FSS_IW          = 16;
	localparam int          FSS_AW          = 12;
	// opcode prefixes
	localparam logic [6:0]  FSS_OP_FILL     = 7'h34;    // 0110 100
	localparam logic [7:0]  FSS_OP_SUBLIT   = 8'h08;    // 0000 1000
	localparam logic [5:0]  FSS_OP_SUBBRW   = 6'h15;    // 0101 01
	localparam logic [15:0] FSS_OP_HALT     = 16'h0003;
	// instruction fields
	localparam int          FSS_BANK_BIT    = 8;
	localparam int          FSS_DEST_BIT    = 9;
	// program word field positions
	localparam int          FSS_FILL_LSB    = 9;
	localparam int          FSS_SUBLIT_LSB  = 8;
	localparam int          FSS_SUBBRW_LSB  = 10;
	localparam int          FSS_FADDR_MSB   = 7;
	localparam logic [7:0]  FSS_ONES        = 8'hff;
	localparam logic [7:0]  FSS_ZERO        = 8'h00;
	localparam logic [7:0]  FSS_IDX_LIMIT   = 8'h5f;
	localparam logic [7:0]  FSS_ACC_HI_BASE = 8'hf0;   // access bank upper part, f0h to ffh
	localparam logic [3:0]  FSS_ACC_HI_BANK = 4'hf;
	localparam logic [3:0]  FSS_ACC_LO_BANK = 4'h0;
	// status bit positions
	localparam int          FSS_ST_C        = 0;
	localparam int          FSS_ST_DC       = 1;
	localparam int          FSS_ST_Z        = 2;
	localparam int          FSS_ST_OV       = 3;
	localparam int          FSS_ST_N        = 4;
	localparam logic [4:0]  FSS_ST_RST      = 5'h00;
	localparam logic [7:0]  FSS_WDG_RST     = 8'h00;

	typedef enum logic [1:0] {
		FSS_Q1 = 2'b00,
		FSS_Q2 = 2'b01,
		FSS_Q3 = 2'b10,
		FSS_Q4 = 2'b11
	} fss_phase_t;

	typedef enum logic [2:0] {
		FSS_I_NONE   = 3'b000,
		FSS_I_FILL   = 3'b001,
		FSS_I_HALT   = 3'b010,
		FSS_I_SUBBRW = 3'b011,
		FSS_I_SUBLIT = 3'b100
	} fss_instr_t;
endpackage

/* File: src/fss_sub_alu.sv */
/*
 * fss_sub_alu: 8-bit subtractor a - b - borrow with status results.
 * Purely combinational; the caller registers its results.
 */
`timescale 1ns/1ps
module fss_sub_alu
	import fss_pkg::*;
#(
	parameter int DW = FSS_DW
) (
	input  wire logic [DW-1:0] a,
	input  wire logic [DW-1:0] b,
	input  wire logic          borrow_in,
	output logic      [DW-1:0] res,
	output logic               carry,
	output logic               dcarry,
	output logic               ovf,
	output logic               neg,
	output logic               zero
);
	logic [DW:0] full;
	logic [4:0]  low_nib;

	// two's complement: a + ~b + carry, carry = not borrow
	assign full    = {1'b0, a} + {1'b0, ~b} + {{DW{1'b0}}, ~borrow_in};
	assign low_nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~borrow_in};
	assign res     = full[DW-1:0];
	assign carry   = full[DW];
	assign dcarry  = low_nib[4];
	assign ovf     = (a[DW-1] != b[DW-1]) && (res[DW-1] != a[DW-1]);
	assign neg     = res[DW-1];
	assign zero    = (res == '0);
endmodule

/* File: src/fss_exec.sv */
/*
 * fss_exec: executes fill-ones, halt, subtract-with-borrow and
 * subtract-from-literal over a four-phase instruction cycle.
 * Assumes the fetch unit presents INSTR stable with INSTR_VALID from Q1
 * through Q4, and data memory answers a read in the cycle after it.
 */
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module fss_exec
	import fss_pkg::*;
#(
	parameter int DW = FSS_DW,
	parameter int AW = FSS_AW
) (
	input  wire logic              SYS_CLK,
	input  wire logic              RST_N,
	input  wire logic [FSS_IW-1:0] INSTR,
	input  wire logic              INSTR_VALID,
	input  wire logic              EXT_SET_EN,
	input  wire logic [3:0]        BANK_SELECT_REG,
	input  wire logic [AW-1:0]     INDEX_BASE,
	input  wire logic [DW-1:0]     MEM_RDATA,
	input  wire logic              WAKE,
	input  wire logic              WAKE_BY_WATCHDOG,
	output logic      [AW-1:0]     MEM_ADDR,
	output logic                   MEM_RD,
	output logic                   MEM_WR,
	output logic      [DW-1:0]     MEM_WDATA,
	output logic      [DW-1:0]     ACC,
	output logic      [4:0]        STATUS,
	output logic                   TIMEOUT_FLAG,
	output logic                   POWERDOWN_FLAG,
	output logic                   WATCHDOG_CLEAR,
	output logic                   HALTED,
	output logic                   OSC_STOP,
	output logic      [1:0]        PHASE
);
	fss_phase_t      phase_r, phase_nxt;
	fss_instr_t      instr_r, instr_nxt;
	logic [FSS_IW-1:0] iw_r;
	logic [DW-1:0]   res_r;
	logic [4:0]      flags_r;
	logic [AW-1:0]   addr_r;
	logic [DW-1:0]   acc_r;
	logic [4:0]      status_r;
	logic            to_r, pd_r, wdc_r, halted_r;
	logic            mem_rd_r, mem_wr_r;
	logic [DW-1:0]   mem_wdata_r;

	// program word fields
	wire [FSS_IW-FSS_FILL_LSB-1:0]   fill_fld   = INSTR[FSS_IW-1:FSS_FILL_LSB];
	wire [FSS_IW-FSS_SUBLIT_LSB-1:0] sublit_fld = INSTR[FSS_IW-1:FSS_SUBLIT_LSB];
	wire [FSS_IW-FSS_SUBBRW_LSB-1:0] subbrw_fld = INSTR[FSS_IW-1:FSS_SUBBRW_LSB];

	// decode
	wire             is_fill   = fill_fld == FSS_OP_FILL;
	wire             is_sublit = sublit_fld == FSS_OP_SUBLIT;
	wire             is_subbrw = subbrw_fld == FSS_OP_SUBBRW;
	wire             is_halt   = INSTR == FSS_OP_HALT;
	wire             run       = !halted_r;

	// phase strobes; a halted core raises none of them
	wire             q1_go     = run && phase_r == FSS_Q1;
	wire             q3_go     = run && phase_r == FSS_Q3;
	wire             q4_go     = run && phase_r == FSS_Q4;
	wire             halt_go   = q4_go && instr_r == FSS_I_HALT;

	assign instr_nxt = is_fill   ? FSS_I_FILL   :
	                   is_halt   ? FSS_I_HALT   :
	                   is_subbrw ? FSS_I_SUBBRW :
	                   is_sublit ? FSS_I_SUBLIT : FSS_I_NONE;

	// address generation
	wire [7:0]       f_addr    = INSTR[FSS_FADDR_MSB:0];
	wire             bank_bit  = INSTR[FSS_BANK_BIT];
	wire             idx_mode  = !bank_bit && EXT_SET_EN && (f_addr <= FSS_IDX_LIMIT);
	wire [AW-1:0]    idx_addr  = INDEX_BASE + {{(AW-8){1'b0}}, f_addr};
	// limitation: the access bank split sits at a fixed f0h boundary
	// access bank vs bank select
	wire [3:0]       acc_bank  = (f_addr >= FSS_ACC_HI_BASE) ? FSS_ACC_HI_BANK : FSS_ACC_LO_BANK;
	wire [AW-1:0]    bank_addr = bank_bit ? {BANK_SELECT_REG, f_addr} : {acc_bank, f_addr};
	wire [AW-1:0]    eff_addr  = idx_mode ? idx_addr : bank_addr;

	wire             sub_lit   = instr_r == FSS_I_SUBLIT;
	wire             sub_brw   = instr_r == FSS_I_SUBBRW;
	wire [DW-1:0]    alu_a     = sub_lit ? iw_r[FSS_FADDR_MSB:0] : acc_r;
	// read data stand in Q3 only, so the subtract works on them live
	wire [DW-1:0]    alu_b     = sub_lit ? acc_r : MEM_RDATA;
	// literal form has no borrow in
	wire             alu_brw   = sub_lit ? 1'b0 : !status_r[FSS_ST_C];
	wire [DW-1:0]    alu_res;
	wire             alu_c, alu_dc, alu_ov, alu_n, alu_z;

	fss_sub_alu #(.DW(DW)) u_alu (
		.a         (alu_a),
		.b         (alu_b),
		.borrow_in (alu_brw),
		.res       (alu_res),
		.carry     (alu_c),
		.dcarry    (alu_dc),
		.ovf       (alu_ov),
		.neg       (alu_n),
		.zero      (alu_z)
	);

	wire [4:0]       alu_flags = {alu_n, alu_ov, alu_z, alu_dc, alu_c};
	wire             is_sub    = sub_brw || sub_lit;
	wire             to_reg    = sub_brw && iw_r[FSS_DEST_BIT];
	wire             wr_reg    = (instr_r == FSS_I_FILL) || to_reg;
	wire             wr_acc    = is_sub && !to_reg;

	assign phase_nxt = fss_phase_t'(phase_r + 2'b01);

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N)
			phase_r <= FSS_Q1;
		else if (run)
			phase_r <= phase_nxt;
	end

	// Q1 decode, Q2 read
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			instr_r  <= FSS_I_NONE;
			iw_r     <= '0;
			addr_r   <= '0;
			mem_rd_r <= 1'b0;
		end else begin
			mem_rd_r <= q1_go && INSTR_VALID && is_subbrw;
			if (q1_go) begin
				instr_r <= INSTR_VALID ? instr_nxt : FSS_I_NONE;
				iw_r    <= INSTR;
				addr_r  <= eff_addr;
			end
		end
	end

	// Q3 process, held for the Q4 write
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			res_r   <= FSS_ZERO;
			flags_r <= FSS_ST_RST;
		end else if (q3_go) begin
			res_r   <= alu_res;
			flags_r <= alu_flags;
		end
	end

	// Q4 write back; the write strobe issues one cycle after Q4 settles
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			mem_wr_r    <= 1'b0;
			mem_wdata_r <= FSS_ZERO;
			acc_r       <= FSS_ZERO;
			status_r    <= FSS_ST_RST;
		end else begin
			mem_wr_r <= q4_go && wr_reg;
			if (q4_go)
				mem_wdata_r <= (instr_r == FSS_I_FILL) ? FSS_ONES : res_r;
			if (q4_go && wr_acc)
				acc_r <= res_r;
			// all five flags (N, OV, Z, DC, C) from the subtractor
			if (q4_go && is_sub)
				status_r <= flags_r;
		end
	end

	// halt entry and wake
	// wake is only seen once halted, so it never meets a halt entry
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			to_r     <= 1'b1;
			pd_r     <= 1'b1;
			wdc_r    <= 1'b0;
			halted_r <= 1'b0;
		end else begin
			wdc_r <= halt_go;
			if (halt_go) begin
				to_r     <= 1'b1;
				pd_r     <= 1'b0;
				halted_r <= 1'b1;
			end else if (halted_r && WAKE) begin
				halted_r <= 1'b0;
				if (WAKE_BY_WATCHDOG)
					to_r <= 1'b0;
			end
		end
	end

	assign MEM_ADDR       = addr_r;
	assign MEM_RD         = mem_rd_r;
	assign MEM_WR         = mem_wr_r;
	assign MEM_WDATA      = mem_wdata_r;
	assign ACC            = acc_r;
	assign STATUS         = status_r;
	assign TIMEOUT_FLAG   = to_r;
	assign POWERDOWN_FLAG = pd_r;
	assign WATCHDOG_CLEAR = wdc_r;
	assign HALTED         = halted_r;
	assign OSC_STOP       = halted_r;
	assign PHASE          = phase_r;
endmodule

/* File: dv/fss_exec_sva.sv */
/* fss_exec_chk: concurrent checks on the ports of fss_exec, bound below.
   assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/1ps
module fss_exec_chk
	import fss_pkg::*;
#(
	parameter int DW = FSS_DW
) (
	input wire logic              SYS_CLK,
	input wire logic              RST_N,
	input wire logic [FSS_IW-1:0] INSTR,
	input wire logic              INSTR_VALID,
	input wire logic              WAKE,
	input wire logic              WAKE_BY_WATCHDOG,
	input wire logic              MEM_RD,
	input wire logic              MEM_WR,
	input wire logic [DW-1:0]     MEM_WDATA,
	input wire logic [DW-1:0]     ACC,
	input wire logic [4:0]        STATUS,
	input wire logic              TIMEOUT_FLAG,
	input wire logic              POWERDOWN_FLAG,
	input wire logic              WATCHDOG_CLEAR,
	input wire logic              HALTED,
	input wire logic              OSC_STOP,
	input wire logic [1:0]        PHASE
);
	// instruction accepted at this edge
	wire          take  = PHASE == FSS_Q1 && INSTR_VALID && !HALTED;
	wire          lit   = take && INSTR[15:8] == FSS_OP_SUBLIT;
	wire [DW-1:0] ldiff = INSTR[7:0] - ACC;
	wire          lnb   = INSTR[7:0] >= ACC;
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	property p_fill; take && INSTR[15:9] == FSS_OP_FILL
		|-> ##4 MEM_WR && MEM_WDATA == FSS_ONES && STATUS == $past(STATUS, 4); endproperty
	a_fill: assert property (p_fill) else $error("fill write wrong");
	property p_halt; take && INSTR == FSS_OP_HALT |-> ##4 WATCHDOG_CLEAR && HALTED; endproperty
	a_halt: assert property (p_halt) else $error("halt entry wrong");
	property p_wdc; WATCHDOG_CLEAR |-> TIMEOUT_FLAG && !POWERDOWN_FLAG; endproperty
	a_wdc: assert property (p_wdc) else $error("halt flags wrong");
	property p_osc; HALTED |-> OSC_STOP && PHASE == FSS_Q1 && !MEM_RD && !MEM_WR; endproperty
	a_osc: assert property (p_osc) else $error("oscillator running in halt");
	property p_wake; HALTED && WAKE && WAKE_BY_WATCHDOG |-> ##[1:4] !TIMEOUT_FLAG; endproperty
	a_wake: assert property (p_wake) else $error("timeout flag kept");
	property p_lit; lit |-> ##4 ACC == $past(ldiff, 4) && STATUS[FSS_ST_C] == $past(lnb, 4);
	endproperty
	a_lit: assert property (p_lit) else $error("literal subtract wrong");
	property p_zero; lit |-> ##4 STATUS[FSS_ST_Z] == (ACC == FSS_ZERO); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_rd; MEM_RD |-> PHASE == FSS_Q2 && $past(PHASE) == FSS_Q1; endproperty
	a_rd: assert property (p_rd) else $error("read outside Q2");
	c_wake: cover property (HALTED && WAKE && !WAKE_BY_WATCHDOG);
	c_wr: cover property (MEM_WR);
	c_zero: cover property (STATUS[FSS_ST_Z]);
endmodule

bind fss_exec fss_exec_chk #(.DW(DW)) u_chk (.*);

/* File: dv/fss_exec_tb.sv */
/* fss_exec_tb: corner and random instruction stream for fss_exec.
   assumes the checker is bound to the design. */
`timescale 1ns/1ps
module fss_exec_tb
	import fss_pkg::*;
;
	logic clk = 0, rst_n = 0, vld = 0, ext = 0, wake = 0, wwd = 0, wr, rd, tof, pdf, wdc, hlt, osc;
	logic [15:0] ins = 0, i;
	logic [3:0] bank_select_reg = 0;
	logic [11:0] ib = 0, addr;
	logic [7:0] rdat = 0, wdat, acc, m_acc = 0, e_wd = 0;
	logic [7:0] fv [4] = '{8'h5f, 8'h60, 8'hef, 8'hf0};
	logic [4:0] st, m_st = 0;
	logic [1:0] ph;
	logic e_wr = 0;
	int err_total = 0, comparisons = 0, seed = 32'he032, r;
	always #10 clk = ~clk;
	fss_exec dut (.SYS_CLK(clk), .RST_N(rst_n), .INSTR(ins), .INSTR_VALID(vld), .EXT_SET_EN(ext),
		.BANK_SELECT_REG(bank_select_reg), .INDEX_BASE(ib), .MEM_RDATA(rdat), .WAKE(wake),
		.WAKE_BY_WATCHDOG(wwd), .MEM_ADDR(addr), .MEM_RD(rd), .MEM_WR(wr), .MEM_WDATA(wdat),
		.ACC(acc), .STATUS(st), .TIMEOUT_FLAG(tof), .POWERDOWN_FLAG(pdf), .WATCHDOG_CLEAR(wdc),
		.HALTED(hlt), .OSC_STOP(osc), .PHASE(ph));
	// {N,OV,Z,DC,C,result} of a - b - bi
	function automatic logic [12:0] sub(logic [7:0] a, logic [7:0] b, logic bi);
		logic [8:0] d;
		logic [4:0] l;
		d = {1'b0, a} - {1'b0, b} - 9'(bi);
		l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(bi);
		return {d[7], (a[7] ^ b[7]) & (d[7] ^ a[7]), d[7:0] == 8'h00, ~l[4], ~d[8], d[7:0]};
	endfunction
	function automatic logic [11:0] ea(logic [7:0] f, logic a);
		if (a) return {bank_select_reg, f};
		if (ext && f <= FSS_IDX_LIMIT) return ib + 12'(f);
		return {(f >= FSS_ACC_HI_BASE) ? FSS_ACC_HI_BANK : FSS_ACC_LO_BANK, f};
	endfunction
	task automatic chk(string n, logic [15:0] s, logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// entered at the edge that opens Q1; results of the previous word are checked first
	task automatic run(logic [15:0] w, logic v, logic [7:0] rv);
		logic [12:0] x;
		logic ff, sb;
		ff = v && w[15:9] == FSS_OP_FILL;
		sb = v && w[15:10] == FSS_OP_SUBBRW;
		ins <= w;
		vld <= v;
		@(negedge clk);
		chk("acc", 16'(acc), 16'(m_acc));
		chk("status", 16'(st), 16'(m_st));
		chk("write", 16'(wr), 16'(e_wr));
		if (e_wr) chk("wdata", 16'(wdat), 16'(e_wd));
		@(posedge clk);
		@(negedge clk);
		if (ff || sb) chk("addr", 16'(addr), 16'(ea(w[7:0], w[8])));
		chk("read", 16'(rd), 16'(sb));
		chk("phase", 16'(ph), 16'(FSS_Q2));
		@(posedge clk);
		rdat <= rv;
		@(posedge clk);
		@(posedge clk);
		// released read data no longer shows the operand
		rdat <= ~rv;
		e_wr = ff || sb && w[9];
		e_wd = FSS_ONES;
		x = sb ? sub(m_acc, rv, ~m_st[FSS_ST_C]) : sub(w[7:0], m_acc, 1'b0);
		if (sb || v && w[15:8] == FSS_OP_SUBLIT) m_st = x[12:8];
		if (sb && w[9]) e_wd = x[7:0];
		if (sb && !w[9] || v && w[15:8] == FSS_OP_SUBLIT) m_acc = x[7:0];
	endtask
	task automatic sleep(logic w);
		run(FSS_OP_HALT, 1'b1, 8'h00);
		vld <= 1'b0;
		@(negedge clk);
		chk("halt", 16'({hlt, osc, wdc, tof, pdf}), 16'h001e);
		@(posedge clk);
		wake <= 1'b1;
		wwd <= w;
		@(posedge clk);
		wake <= 1'b0;
		repeat (12) begin
			@(negedge clk);
			if (!hlt && ph === FSS_Q4) break;
		end
		chk("timeout", 16'(tof), 16'(!w));
		@(posedge clk);
	endtask
	initial begin
		#200000;
		err_total++;
		conclude();
	end
	initial begin
		@(posedge clk);
		@(negedge clk);
		chk("reset", 16'({tof, pdf, hlt}), 16'h0006);
		@(posedge clk);
		rst_n <= 1'b1;
		run(16'h0802, 1, 0);
		run(16'h0802, 1, 0);
		run(16'h0801, 1, 0);
		run(16'h0800, 1, 0);
		run(16'hffff, 1, 0);
		run(16'h0855, 0, 0);
		for (int k = 0; k < 16; k++) begin
			ext <= k[3];
			run({FSS_OP_FILL, k[2], fv[k[1:0]]}, 1, 0);
		end
		sleep(1'b1);
		sleep(1'b0);
		repeat (200) begin
			r = $random(seed);
			bank_select_reg <= r[3:0];
			ib <= r[15:4];
			ext <= r[16];
			case (r[18:17])
				2'd0: i = {FSS_OP_FILL, r[27:19]};
				2'd1: i = {FSS_OP_SUBLIT, r[26:19]};
				default: i = {FSS_OP_SUBBRW, r[29:20]};
			endcase
			run(i, 1, 8'($random(seed)));
		end
		run(16'h0000, 0, 0);
		conclude();
	end
endmodule
